// [include/scd_pkg.sv]
// Shared constants and types for the subtract and compare datapath
package scd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned SHORT_W = 4;
  localparam int unsigned OPC_W = 8;
  localparam int unsigned ADDR_W = 4;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [OPC_W-1:0] OPC_SUBTRACT_MEMORY_FORM = 8'h5b;
  localparam logic [OPC_W-1:0] OPC_SUBTRACT_REGISTER_FORM = 8'h0b;
  localparam logic [OPC_W-1:0] OPC_SUBTRACT_IMMEDIATE_FORM = 8'hfb;
  localparam logic [OPC_W-1:0] OPC_SUBTRACT_SHORT_IMMEDIATE_FORM = 8'h27;
  localparam logic [OPC_W-1:0] OPC_HALFWORD_SUBTRACT_MEMORY_FORM = 8'h4b;
  localparam logic [OPC_W-1:0] OPC_HALFWORD_SUBTRACT_IMMEDIATE_FORM = 8'hcb;
  localparam logic [OPC_W-1:0] OPC_COMPARE_MEMORY_FORM = 8'h59;
  localparam logic [OPC_W-1:0] OPC_COMPARE_REGISTER_FORM = 8'h09;
  localparam logic [OPC_W-1:0] OPC_COMPARE_IMMEDIATE_FORM = 8'hf9;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'h2;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STATUS_ILLEGAL_BIT = 4;
  localparam int unsigned CC_W = 4;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Second operand source, one-hot
  typedef enum logic [5:0] {
    SCD_SEL_MEM_FULL = 6'h01,
    SCD_SEL_REG = 6'h02,
    SCD_SEL_IMM_FULL = 6'h04,
    SCD_SEL_SHORT = 6'h08,
    SCD_SEL_MEM_HALF = 6'h10,
    SCD_SEL_IMM_HALF = 6'h20
  } scd_sel_e;

  // Condition code, carry first as in the program status word
  typedef struct packed {
    logic c;
    logic v;
    logic g;
    logic l;
  } scd_cc_s;

  typedef struct packed {
    logic valid;
    logic [OPC_W-1:0] opcode;
    logic [WORD_W-1:0] first_data;
    logic [WORD_W-1:0] second_data;
    logic [WORD_W-1:0] index_data;
    logic [WORD_W-1:0] immediate_field;
    logic [SHORT_W-1:0] short_data;
    logic [WORD_W-1:0] mem_data;
  } scd_issue_s;

  typedef struct packed {
    logic valid;
    logic write_back;
    logic [WORD_W-1:0] data;
    scd_cc_s cc;
  } scd_result_s;

  typedef struct packed {
    logic enable;
    logic illegal;
    logic res_valid;
    logic write_back;
    logic [WORD_W-1:0] data;
    scd_cc_s cc;
    logic [WORD_W-1:0] rdata;
  } scd_state_s;

endpackage

// [src/scd_datapath.sv]
// Subtract and compare execution datapath with its register port
//
// Overview of operation
// - Fullword subtract writes difference to first register
// - Subtract sets greater or less by sign
// - Short field zero extended to fullword
// - Fullword immediate plus index register
// - Halfword operand sign extended, then subtracted
// - Halfword immediate sign extended plus index
// - Opcodes 4b and cb are halfword subtracts
// - Compare only sets condition code (here it also loads the result register with the first operand)
// - Overflow after compare is undefined
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module scd_datapath (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire scd_pkg::scd_issue_s issue,
  output scd_pkg::scd_result_s result,
  input wire logic [scd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [scd_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [scd_pkg::WORD_W-1:0] reg_rdata
);
  import scd_pkg::*;

  scd_state_s st;
  scd_state_s next_st;
  scd_sel_e dec_sel;
  logic dec_cmp;
  logic dec_legal;
  logic take;
  logic [WORD_W-1:0] op2;
  logic [WORD_W:0] diff_ext;
  logic sub_ovf;
  logic cmp_lt;
  logic cmp_gt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Memory operands arrive already aligned by the issuing program
  // fullword alignment relied on
  always_comb begin
    dec_sel = SCD_SEL_REG;
    dec_cmp = 1'b0;
    dec_legal = 1'b1;
    unique case (issue.opcode)
      OPC_SUBTRACT_MEMORY_FORM: dec_sel = SCD_SEL_MEM_FULL;
      OPC_SUBTRACT_REGISTER_FORM: dec_sel = SCD_SEL_REG;
      OPC_SUBTRACT_IMMEDIATE_FORM: dec_sel = SCD_SEL_IMM_FULL;
      OPC_SUBTRACT_SHORT_IMMEDIATE_FORM: dec_sel = SCD_SEL_SHORT;
      OPC_HALFWORD_SUBTRACT_MEMORY_FORM: dec_sel = SCD_SEL_MEM_HALF;
      OPC_HALFWORD_SUBTRACT_IMMEDIATE_FORM: dec_sel = SCD_SEL_IMM_HALF;
      OPC_COMPARE_MEMORY_FORM: begin
        dec_sel = SCD_SEL_MEM_FULL;
        dec_cmp = 1'b1;
      end
      OPC_COMPARE_REGISTER_FORM: begin
        dec_sel = SCD_SEL_REG;
        dec_cmp = 1'b1;
      end
      OPC_COMPARE_IMMEDIATE_FORM: begin
        dec_sel = SCD_SEL_IMM_FULL;
        dec_cmp = 1'b1;
      end
      default: dec_legal = 1'b0;
    endcase
  end

  scd_operand u_operand (
    .sel(dec_sel),
    .issue(issue),
    .op2(op2)
  );

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  assign take = issue.valid & st.enable;
  assign diff_ext = {1'b0, issue.first_data} - {1'b0, op2};
  assign sub_ovf = (issue.first_data[WORD_W-1] ^ op2[WORD_W-1]) &
                   (diff_ext[WORD_W-1] ^ issue.first_data[WORD_W-1]);
  assign cmp_lt = $signed(issue.first_data) < $signed(op2);
  assign cmp_gt = $signed(issue.first_data) > $signed(op2);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.res_valid = 1'b0;
    next_st.write_back = 1'b0;
    next_st.rdata = '0;
    if (take && dec_legal) begin
      next_st.res_valid = 1'b1;
      if (dec_cmp) begin
        next_st.write_back = 1'b0;
        next_st.data = issue.first_data;
        next_st.cc.c = cmp_lt;
        next_st.cc.l = cmp_lt;
        next_st.cc.g = cmp_gt;
        next_st.cc.v = sub_ovf;
      end else begin
        next_st.write_back = 1'b1;
        next_st.data = diff_ext[WORD_W-1:0];
        next_st.cc.l = diff_ext[WORD_W-1];
        next_st.cc.g = ~diff_ext[WORD_W-1] &
                       (diff_ext[WORD_W-1:0] != '0);
        next_st.cc.v = sub_ovf;
        next_st.cc.c = diff_ext[WORD_W];
      end
    end
    if (reg_wr && reg_addr == REG_CTRL) begin
      next_st.enable = reg_wdata[CTRL_ENABLE_BIT];
    end
    if (reg_wr && reg_addr == REG_STATUS &&
        reg_wdata[STATUS_ILLEGAL_BIT]) begin
      next_st.illegal = 1'b0;
    end
    // Set after clear so a new fault is never lost
    if (take && !dec_legal) begin
      next_st.illegal = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: next_st.rdata[CTRL_ENABLE_BIT] = st.enable;
        REG_STATUS: begin
          next_st.rdata[CC_W-1:0] = st.cc;
          next_st.rdata[STATUS_ILLEGAL_BIT] = st.illegal;
        end
        REG_RESULT: next_st.rdata = st.data;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.enable <= CTRL_ENABLE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign result = '{valid: st.res_valid, write_back: st.write_back,
                    data: st.data, cc: st.cc};
  assign reg_rdata = st.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sub_result_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && dec_legal && !dec_cmp |=>
    result.data == $past(issue.first_data) - $past(op2)
  ) else $error("subtract result wrong");

  a_sub_sign_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    result.valid && result.write_back |->
    result.cc.l == result.data[WORD_W-1] &&
    result.cc.g == (!result.data[WORD_W-1] && result.data != '0)
  ) else $error("subtract sign flags wrong");

  a_short_zero_ext: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue.opcode == OPC_SUBTRACT_SHORT_IMMEDIATE_FORM |->
    op2[WORD_W-1:SHORT_W] == '0 && op2[SHORT_W-1:0] == issue.short_data
  ) else $error("short operand not zero extended");

  a_imm_index_sum: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue.opcode == OPC_SUBTRACT_IMMEDIATE_FORM |->
    op2 == issue.immediate_field + issue.index_data
  ) else $error("fullword immediate operand wrong");

  a_half_sub_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && issue.opcode == OPC_HALFWORD_SUBTRACT_MEMORY_FORM |=>
    result.data == $past(issue.first_data) -
      {{(WORD_W-HALF_W){$past(issue.mem_data[HALF_W-1])}},
       $past(issue.mem_data[HALF_W-1:0])}
  ) else $error("halfword subtract wrong");

  a_half_imm_operand: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue.opcode == OPC_HALFWORD_SUBTRACT_IMMEDIATE_FORM |->
    op2 == {{(WORD_W-HALF_W){issue.immediate_field[HALF_W-1]}},
            issue.immediate_field[HALF_W-1:0]} + issue.index_data
  ) else $error("halfword immediate operand wrong");

  a_half_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && (issue.opcode == OPC_HALFWORD_SUBTRACT_MEMORY_FORM ||
             issue.opcode == OPC_HALFWORD_SUBTRACT_IMMEDIATE_FORM) |=>
    result.valid && result.write_back
  ) else $error("halfword opcode not executed");

  a_cmp_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && dec_legal && dec_cmp |=>
    result.valid && !result.write_back &&
    result.data == $past(issue.first_data)
  ) else $error("compare wrote a result");

  a_cmp_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && dec_legal && dec_cmp |=>
    result.cc.c == result.cc.l && !(result.cc.g && result.cc.l) &&
    result.cc.l == ($signed($past(issue.first_data)) <
                    $signed($past(op2))) &&
    result.cc.g == ($signed($past(issue.first_data)) >
                    $signed($past(op2)))
  ) else $error("compare flags wrong");

  a_sub_ovf_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && dec_legal && !dec_cmp |=>
    result.cc.c == ($past(issue.first_data) < $past(op2)) &&
    result.cc.v == ($signed($past(issue.first_data)) -
                    $signed($past(op2)) != $signed(result.data) ||
                    ($past(issue.first_data[WORD_W-1]) !=
                     $past(op2[WORD_W-1]) &&
                     result.data[WORD_W-1] !=
                     $past(issue.first_data[WORD_W-1])))
  ) else $error("overflow or borrow wrong");

  a_reg_operand: assert property (@(posedge ref_clk) disable iff (!rst_n)
    issue.opcode == OPC_SUBTRACT_REGISTER_FORM ||
    issue.opcode == OPC_COMPARE_REGISTER_FORM |->
    op2 == issue.second_data
  ) else $error("register operand wrong");

endmodule
`default_nettype wire

// [src/scd_operand.sv]
// Second operand formation for the subtract and compare datapath
`timescale 1ns/1ps
`default_nettype none
module scd_operand (
  input wire scd_pkg::scd_sel_e sel,
  input wire scd_pkg::scd_issue_s issue,
  output logic [scd_pkg::WORD_W-1:0] op2
);
  import scd_pkg::*;

  logic [WORD_W-1:0] mem_half_ext;
  logic [WORD_W-1:0] imm_half_ext;

  // ----------------------------------------------------------------
  // Sign extension of halfword operands
  // ----------------------------------------------------------------
  // halfword sign copy
  assign mem_half_ext = {{(WORD_W-HALF_W){issue.mem_data[HALF_W-1]}},
                         issue.mem_data[HALF_W-1:0]};
  assign imm_half_ext = {{(WORD_W-HALF_W){issue.immediate_field[HALF_W-1]}},
                         issue.immediate_field[HALF_W-1:0]};

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  always_comb begin
    unique case (sel)
      SCD_SEL_MEM_FULL: op2 = issue.mem_data;
      SCD_SEL_REG: op2 = issue.second_data;
      SCD_SEL_IMM_FULL: op2 = issue.immediate_field + issue.index_data;
      SCD_SEL_SHORT: op2 = {{(WORD_W-SHORT_W){1'b0}}, issue.short_data};
      SCD_SEL_MEM_HALF: op2 = mem_half_ext;
      SCD_SEL_IMM_HALF: op2 = imm_half_ext + issue.index_data;
      default: op2 = '0;
    endcase
  end

endmodule
`default_nettype wire

// [tb/scd_feeder.sv]
// Decoder, register file and operand memory model feeding the datapath
`timescale 1ns/1ps
`default_nettype none
module scd_feeder (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] opcode,
  input wire logic [3:0] first_reg,
  input wire logic [3:0] second_reg,
  input wire logic [3:0] index_reg,
  input wire logic [31:0] imm,
  input wire logic [3:0] short_field,
  input wire logic [3:0] maddr,
  output scd_pkg::scd_issue_s issue,
  input wire scd_pkg::scd_result_s result
);
  import scd_pkg::*;
  // ----------------------------------------------------------------
  // Register file, halfword memory and operand routing
  // ----------------------------------------------------------------
  logic [31:0] gpr [16];
  logic [15:0] mem [16];
  logic [3:0] first_reg_q;
  always_comb begin
    issue.valid = go;
    issue.opcode = opcode;
    issue.first_data = gpr[first_reg];
    issue.second_data = gpr[second_reg];
    issue.index_data = (index_reg == 4'h0) ? 32'h0 : gpr[index_reg];
    issue.immediate_field = imm;
    issue.short_data = short_field;
    issue.mem_data = {mem[{maddr[3:1], 1'b0}], mem[{maddr[3:1], 1'b1}]};
    if (opcode[7:4] == 4'h4) begin
      issue.mem_data = {~mem[maddr], mem[maddr]};
    end
  end
  // Write back into the register named when the issue was taken
  always @(posedge ref_clk) begin
    if (go) begin
      first_reg_q <= first_reg;
    end
    if (result.valid && result.write_back) begin
      gpr[first_reg_q] <= result.data;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_scd_datapath.sv]
// Self-checking bench for the subtract and compare datapath
`timescale 1ns/1ps
`default_nettype none
module tb_scd_datapath;
  import scd_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic [7:0] opcode = 8'h0;
  logic [3:0] first_reg = 4'h0;
  logic [3:0] second_reg = 4'h0;
  logic [3:0] index_reg = 4'h0;
  logic [3:0] short_field = 4'h0;
  logic [3:0] maddr = 4'h0;
  logic [31:0] imm = 32'h0;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [WORD_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [WORD_W-1:0] reg_rdata;
  scd_issue_s issue;
  scd_result_s result;
  int error_cnt = 0;
  int comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  scd_feeder pm (.ref_clk(ref_clk), .go(go), .opcode(opcode),
    .first_reg(first_reg), .second_reg(second_reg),
    .index_reg(index_reg), .imm(imm), .short_field(short_field),
    .maddr(maddr), .issue(issue), .result(result));
  scd_datapath dut (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue),
    .result(result), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Issue one instruction and check its answer one cycle later
  task automatic exec(input logic [7:0] o, input logic [3:0] a1,
      input logic [3:0] a2, input logic [3:0] ax, input logic [31:0] ai,
      input logic [3:0] as, input logic [3:0] am, input bit live);
    logic [31:0] a, b, ix, d;
    logic [15:0] h;
    logic lt, gt;
    logic [3:0] cc_exp;
    @(posedge ref_clk);
    go <= 1'b1;
    opcode <= o;
    first_reg <= a1;
    second_reg <= a2;
    index_reg <= ax;
    imm <= ai;
    short_field <= as;
    maddr <= am;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    a = pm.gpr[a1];
    ix = (ax == 4'h0) ? 32'h0 : pm.gpr[ax];
    h = pm.mem[am];
    case (o)
      OPC_SUBTRACT_REGISTER_FORM, OPC_COMPARE_REGISTER_FORM: b = pm.gpr[a2];
      OPC_SUBTRACT_IMMEDIATE_FORM, OPC_COMPARE_IMMEDIATE_FORM: b = ai + ix;
      OPC_SUBTRACT_SHORT_IMMEDIATE_FORM: b = {28'h0, as};
      OPC_HALFWORD_SUBTRACT_MEMORY_FORM: b = {{16{h[15]}}, h};
      OPC_HALFWORD_SUBTRACT_IMMEDIATE_FORM: b = {{16{ai[15]}}, ai[15:0]} + ix;
      default: b = {pm.mem[{am[3:1], 1'b0}], pm.mem[{am[3:1], 1'b1}]};
    endcase
    d = a - b;
    lt = $signed(a) < $signed(b);
    gt = $signed(a) > $signed(b);
    if (!live) begin
      chk({31'h0, result.valid}, 32'h0);
    end else if (o[1]) begin
      cc_exp = {a < b, (a[31] != b[31]) && (d[31] != a[31]),
        !d[31] && (d != 32'h0), d[31]};
      chk({30'h0, result.valid, result.write_back}, 32'h3);
      chk(result.data, d);
      chk({28'h0, result.cc}, {28'h0, cc_exp});
    end else begin
      chk({30'h0, result.valid, result.write_back}, 32'h2);
      chk(result.data, a);
      chk({28'h0, result.cc & 4'hb}, {28'h0, lt, 1'b0, gt, lt});
    end
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    logic [31:0] v;
    pm.gpr = '{32'h0, 32'h44444444, 32'h44444444, 32'h23456789, 32'h0,
      32'h00123456, 32'h10, 32'h80000000, 32'h1, 32'hf4567891, 32'h3123,
      32'h10, 32'h5, 32'h0, 32'h0, 32'h0};
    pm.mem = '{16'hffff, 16'h4321, 16'h0, 16'hfff4, 16'h0, 16'h0, 16'h0,
      16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(REG_CTRL, v);
    chk(v, 32'h1);
    exec(8'h0b, 4'h1, 4'h2, 4'h0, 32'h0, 4'h0, 4'h0, 1'b1);
    exec(8'h5b, 4'h3, 4'h0, 4'h0, 32'h0, 4'h0, 4'h0, 1'b1);
    exec(8'hfb, 4'hc, 4'h0, 4'h6, 32'h100, 4'h0, 4'h0, 1'b1);
    exec(8'h27, 4'h4, 4'h0, 4'h0, 32'h0, 4'hf, 4'h0, 1'b1);
    exec(8'h4b, 4'h5, 4'h0, 4'h0, 32'h0, 4'h0, 4'h3, 1'b1);
    exec(8'hcb, 4'hb, 4'h0, 4'h6, 32'h5a5a8000, 4'h0, 4'h0, 1'b1);
    exec(8'h0b, 4'h7, 4'h8, 4'h0, 32'h0, 4'h0, 4'h0, 1'b1);
    rd(REG_RESULT, v);
    chk(v, 32'h7fffffff);
    $display("test subtract forms done");
    exec(8'h09, 4'h9, 4'ha, 4'h0, 32'h0, 4'h0, 4'h0, 1'b1);
    @(posedge ref_clk);
    #1;
    chk(pm.gpr[9], 32'hf4567891);
    exec(8'h59, 4'h9, 4'h0, 4'h0, 32'h0, 4'h0, 4'h0, 1'b1);
    exec(8'hf9, 4'h1, 4'h0, 4'h0, 32'h0, 4'h0, 4'h0, 1'b1);
    exec(8'hf9, 4'h3, 4'h0, 4'h6, 32'hfffffff0, 4'h0, 4'h0, 1'b1);
    rd(REG_STATUS, v);
    chk(v & 32'hfffffffb, 32'h2);
    rd(REG_RESULT, v);
    chk(v, pm.gpr[3]);
    $display("test compare forms done");
    exec(8'h49, 4'h2, 4'h2, 4'h0, 32'h0, 4'h0, 4'h0, 1'b0);
    rd(REG_STATUS, v);
    chk(v & 32'h10, 32'h10);
    wr(REG_STATUS, 32'h10);
    rd(REG_STATUS, v);
    chk(v & 32'h10, 32'h0);
    rd(4'hf, v);
    chk(v, 32'h0);
    wr(REG_CTRL, 32'h0);
    exec(8'h0b, 4'h2, 4'h2, 4'h0, 32'h0, 4'h0, 4'h0, 1'b0);
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, v);
    chk(v, 32'h1);
    $display("test register port done");
    report_and_stop();
  end
endmodule
`default_nettype wire
